// *** verilog/sssp_top.sv ***
// Register access over Wishbone was chosen for this implementation.
`default_nettype none
`include "sssp_defines.svh"
module sssp_top
  import sssp_pkg::*;
#(
  parameter int ADR_W = 10
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Serial pins
  input  wire logic             sclk_i,
  input  wire logic             sdin_i,
  output logic                  sdout_o,
  output logic                  sdout_oe_n_o,
  // Interrupts
  output logic                  irq_n_o,
  output logic                  irq_o
);
  // ==========================================================
  // Elaboration checks: the register map needs ten address bits
  if (ADR_W < 10) begin : g_adr_chk
    $error("ADR_W must be at least 10");
  end

  // ==========================================================
  // Pin synchronisers
  logic sclk_s;
  logic sdin_s;
  sssp_sync u_sync_clk (.clk_i(clk_i), .rst_i(rst_i), .async_i(sclk_i), .sync_o(sclk_s));
  sssp_sync u_sync_din (.clk_i(clk_i), .rst_i(rst_i), .async_i(sdin_i), .sync_o(sdin_s));

  // ==========================================================
  // State
  sssp_byte_t shift_data_reg_r, shift_data_reg_nxt;
  sssp_cnt_t  cnt_r,            cnt_nxt;
  logic       sclk_d_r,         sclk_d_nxt;
  logic       ser_ien_r,        ser_ien_nxt;
  logic       irq_n_r,          irq_n_nxt;
  logic       od_r,             od_nxt;
  logic       sdout_r,          sdout_nxt;
  logic       oe_n_r,           oe_n_nxt;
  logic       sts_r,            sts_nxt;
  logic       ien_r,            ien_nxt;
  logic       irq_r,            irq_nxt;
  logic       ack_r,            ack_nxt;
  logic [31:0] dat_r,           dat_nxt;

  logic req;
  logic wr;
  logic fall;
  logic count_terminal_output;
  logic byte_done;
  logic [ADR_W-1:0] a;

  always_comb begin
    a    = adr_i & ~ADR_W'(3);
    req  = cyc_i && stb_i && !ack_r;
    wr   = req && we_i && sel_i[0];
    // Terminal output low once eight bits are in; gates the serial clock
    count_terminal_output = (cnt_r != `SSSP_BITS_PER_BYTE);
    fall = sclk_d_r && !sclk_s;
    byte_done = fall && count_terminal_output && (cnt_r == `SSSP_BITS_PER_BYTE - 4'h1);
  end

  // ==========================================================
  // Shift engine and interrupt
  always_comb begin
    shift_data_reg_nxt = shift_data_reg_r;
    cnt_nxt            = cnt_r;
    sclk_d_nxt         = sclk_s;
    ser_ien_nxt        = ser_ien_r;
    irq_n_nxt          = 1'b1;
    if (wr && a == `SSSP_ADR_SHIFT_DATA) begin
      // A write resets the counter and wins over a coincident edge
      shift_data_reg_nxt = dat_i[7:0];
      cnt_nxt            = `SSSP_CNT_RST;
      ser_ien_nxt        = 1'b1;
    end else if (fall && count_terminal_output) begin
      shift_data_reg_nxt = {shift_data_reg_r[6:0], sdin_s};
      cnt_nxt            = cnt_r + 4'h1;
    end
    if (wr && a == `SSSP_ADR_IRQ_DISABLE)
      ser_ien_nxt = 1'b0;
    // One-cycle low pulse gives the core a falling edge
    if (byte_done && ser_ien_r && !(wr && a == `SSSP_ADR_SHIFT_DATA))
      irq_n_nxt = 1'b0;
  end

  // Edges after the eighth are dropped until software writes the data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_data_reg_r <= `SSSP_SHIFT_RST;
      cnt_r            <= `SSSP_CNT_RST;
      // Parked high like the idle pin, so reset cannot fake a falling edge
      sclk_d_r         <= 1'b1;
      ser_ien_r        <= 1'b0;
      irq_n_r          <= 1'b1;
    end else begin
      shift_data_reg_r <= shift_data_reg_nxt;
      cnt_r            <= cnt_nxt;
      sclk_d_r         <= sclk_d_nxt;
      ser_ien_r        <= ser_ien_nxt;
      irq_n_r          <= irq_n_nxt;
    end
  end

  // ==========================================================
  // Output pin: shift register MSB reaches the pin only in open-drain mode
  always_comb begin
    sdout_nxt = 1'b0;
    oe_n_nxt  = !(od_r && !shift_data_reg_r[7]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdout_r          <= 1'b0;
      oe_n_r           <= 1'b1;
    end else begin
      sdout_r          <= sdout_nxt;
      oe_n_r           <= oe_n_nxt;
    end
  end

  // ==========================================================
  // Sticky status, enable, level interrupt
  always_comb begin
    sts_nxt = sts_r;
    ien_nxt = ien_r;
    od_nxt  = od_r;
    if (wr && a == `SSSP_ADR_IRQ_CLEAR && dat_i[`SSSP_EVT_BYTE_DONE])
      sts_nxt = 1'b0;
    // Set wins over a clear in the same cycle
    if (byte_done)
      sts_nxt = 1'b1;
    if (wr && a == `SSSP_ADR_IRQ_ENABLE)
      ien_nxt = dat_i[`SSSP_EVT_BYTE_DONE];
    if (wr && a == `SSSP_ADR_CONFIG)
      od_nxt = dat_i[`SSSP_CFG_OUT_OD];
    irq_nxt = sts_nxt && ien_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      od_r             <= 1'b0;
      sts_r            <= 1'b0;
      ien_r            <= 1'b0;
      irq_r            <= 1'b0;
    end else begin
      od_r             <= od_nxt;
      sts_r            <= sts_nxt;
      ien_r            <= ien_nxt;
      irq_r            <= irq_nxt;
    end
  end

  // ==========================================================
  // Wishbone: one wait state, unmapped reads return zero
  always_comb begin
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;
    if (req && !we_i) begin
      case (a)
        `SSSP_ADR_SHIFT_DATA:  dat_nxt = {24'h00_0000, shift_data_reg_r};
        `SSSP_ADR_IRQ_STATUS:  dat_nxt = {31'h0000_0000, sts_r};
        `SSSP_ADR_IRQ_ENABLE:  dat_nxt = {31'h0000_0000, ien_r};
        `SSSP_ADR_CONFIG:      dat_nxt = {31'h0000_0000, od_r};
        default:               dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data is registered so that dat_o comes straight from a flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r            <= 1'b0;
      dat_r            <= 32'h0000_0000;
    end else begin
      ack_r            <= ack_nxt;
      dat_r            <= dat_nxt;
    end
  end

  assign dat_o        = dat_r;
  assign ack_o        = ack_r;
  assign sdout_o      = sdout_r;
  assign sdout_oe_n_o = oe_n_r;
  assign irq_n_o      = irq_n_r;
  assign irq_o        = irq_r;

  // ==========================================================
  // Assertions
  AST_CNT_MAX: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_r <= `SSSP_BITS_PER_BYTE) else $error("counter above eight");
  AST_STOP_AT_EIGHT: assert property (@(posedge clk_i) disable iff (rst_i)
    (cnt_r == 4'h8 && !(wr && a == `SSSP_ADR_SHIFT_DATA)) |=> $stable(shift_data_reg_r) && cnt_r == 4'h8)
    else $error("clocking not gated after eight bits");
  AST_SHIFT_MSB: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall && count_terminal_output && !(wr && a == `SSSP_ADR_SHIFT_DATA))
      |=> shift_data_reg_r[7:1] == $past(shift_data_reg_r[6:0])) else $error("shift not msb first");
  AST_ADVANCE: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall && count_terminal_output && !(wr && a == `SSSP_ADR_SHIFT_DATA))
      |=> cnt_r == $past(cnt_r) + 4'h1) else $error("counter did not advance");
  AST_WR_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a == `SSSP_ADR_SHIFT_DATA) |=> cnt_r == 4'h0 && ser_ien_r) else $error("write did not reset counter");
  AST_DISABLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a == `SSSP_ADR_IRQ_DISABLE) |=> !ser_ien_r) else $error("disable write ignored");
  AST_IRQ_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && ser_ien_r && !(wr && a == `SSSP_ADR_SHIFT_DATA)) |=> !irq_n_o ##1 irq_n_o)
    else $error("missing interrupt pulse");
  AST_IRQ_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(irq_n_o) |-> $past(byte_done) && $past(ser_ien_r)) else $error("spurious interrupt");
  AST_READ_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && !fall) |=> $stable(cnt_r) && $stable(ser_ien_r)) else $error("read disturbed state");
  AST_RESET_OFF: assert property (@(posedge clk_i) $fell(rst_i) |-> !ser_ien_r)
    else $error("interrupt enabled after reset");
  COV_BYTE: cover property (@(posedge clk_i) disable iff (rst_i) byte_done);
  COV_IRQ: cover property (@(posedge clk_i) disable iff (rst_i) $fell(irq_n_o));
  COV_LEVEL: cover property (@(posedge clk_i) disable iff (rst_i) irq_o);
  COV_RESTART: cover property (@(posedge clk_i) disable iff (rst_i)
    wr && a == `SSSP_ADR_SHIFT_DATA && cnt_r != 4'h0 && count_terminal_output);
  COV_EXTRA_EDGE: cover property (@(posedge clk_i) disable iff (rst_i) fall && !count_terminal_output);

  // ==========================================================
  // Link assertions
  AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (rst_i)
    (fall && count_terminal_output && !(wr && a == `SSSP_ADR_SHIFT_DATA))
      |=> shift_data_reg_r[0] == $past(sdin_s)) else $error("serial input bit lost");
  AST_HOLD_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!fall && !(wr && a == `SSSP_ADR_SHIFT_DATA)) |=> $stable(cnt_r) && $stable(shift_data_reg_r))
    else $error("shift state moved without a clock edge");
  AST_WR_LOADS: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a == `SSSP_ADR_SHIFT_DATA) |=> shift_data_reg_r == $past(dat_i[7:0]))
    else $error("data write not loaded");
  AST_OE_FOLLOWS: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sdout_oe_n_o == !($past(od_r) && !$past(shift_data_reg_r[7])))
    else $error("open-drain enable does not follow the shift register");
  AST_SDOUT_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    !sdout_o) else $error("open-drain data value not low");

  // ==========================================================
  // Bus assertions
  AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o) else $error("request not acknowledged");
  AST_ACK_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !ack_o) else $error("acknowledge without a request");
  AST_ACK_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("acknowledge longer than one cycle");
  AST_RD_IDLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h0000_0000) else $error("read data outside acknowledge");
  AST_RD_SHIFT: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && a == `SSSP_ADR_SHIFT_DATA) |=> dat_o[7:0] == $past(shift_data_reg_r))
    else $error("data read does not return the shift register");
  AST_RD_DISABLE_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !we_i && a == `SSSP_ADR_IRQ_DISABLE) |=> dat_o == 32'h0000_0000)
    else $error("disable register read not zero");
  AST_ENABLE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a == `SSSP_ADR_IRQ_ENABLE) |=> ien_r == $past(dat_i[0]))
    else $error("enable write not taken");
  AST_CFG_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && a == `SSSP_ADR_CONFIG) |=> od_r == $past(dat_i[0]))
    else $error("configuration write not taken");

  // ==========================================================
  // Interrupt assertions
  AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == (sts_r && ien_r)) else $error("level interrupt disagrees with status and enable");
  AST_STS_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    byte_done |=> sts_r) else $error("byte done not recorded");
  AST_STS_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    (sts_r && !(wr && a == `SSSP_ADR_IRQ_CLEAR && dat_i[`SSSP_EVT_BYTE_DONE])) |=> sts_r)
    else $error("status bit lost without a clear");
  AST_IRQ_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
    !irq_n_o |=> irq_n_o) else $error("interrupt pulse longer than one cycle");
  AST_NO_IRQ_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i)
    !ser_ien_r |=> irq_n_o) else $error("interrupt pulse while disabled");
endmodule // sssp_top
`default_nettype wire

// *** verilog/sssp_defines.svh ***
`ifndef SSSP_DEFINES_SVH
`define SSSP_DEFINES_SVH
// Register byte addresses (printed offsets are not all multiples of four)
`define SSSP_IDX_IRQ_DISABLE  8'hC2
`define SSSP_IDX_SHIFT_DATA   8'hDD
`define SSSP_ADR_IRQ_DISABLE  10'h308
`define SSSP_ADR_SHIFT_DATA   10'h374
`define SSSP_ADR_IRQ_STATUS   10'h000
`define SSSP_ADR_IRQ_CLEAR    10'h004
`define SSSP_ADR_IRQ_ENABLE   10'h008
`define SSSP_ADR_CONFIG       10'h00C
// Field positions
`define SSSP_EVT_BYTE_DONE    0
`define SSSP_CFG_OUT_OD       0
// Reset values
`define SSSP_SHIFT_RST        8'h00
`define SSSP_CNT_RST          4'h0
`define SSSP_BITS_PER_BYTE    4'h8
`endif

// *** verilog/sssp_pkg.sv ***
`default_nettype none
package sssp_pkg;
  typedef logic [7:0] sssp_byte_t;
  typedef logic [3:0] sssp_cnt_t;
endpackage
`default_nettype wire

// *** verilog/sssp_sync.sv ***
`default_nettype none
module sssp_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous level in, synchronous level out
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_r;
  logic meta_nxt;
  logic sync_r;
  logic sync_nxt;

  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule // sssp_sync
`default_nettype wire

// *** verif/sssp_partner.sv ***
`default_nettype none
module sssp_partner (
  // Serial pins
  output var logic       sclk_o,
  output var logic       sd_o,
  input  wire logic      oe_n_i,
  // Byte seen on the line
  output var logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Idle: clock parked high, data left to the pull-up
  initial begin
    sclk_o = 1'b1;
    sd_o   = 1'b1;
    rx_o   = 8'h00;
  end
  // A long half period stretches the clock as slow software would
  task automatic xfer(input logic [7:0] tx, input int nb, input int half);
    for (int i = 7; i > 7 - nb; i--) begin
      sd_o = tx[i];
      #(half);
      rx_o[i] = sd_o & oe_n_i;
      sclk_o = 1'b0;
      #(half);
      sclk_o = 1'b1;
    end
    sd_o = 1'b1;
    #(half);
  endtask
endmodule // sssp_partner
`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none
`include "sssp_defines.svh"
module testbench;
  import sssp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cyc_i = 1'b0;
  logic       stb_i = 1'b0;
  logic       we_i  = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'hF;
  logic [3:0] sel_v = 4'hF;
  logic [31:0] dat_o;
  logic       ack_o, sclk, sd, sdout_o, oe_n, irq_n_o, irq_o;
  sssp_byte_t rx, q, d, p;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         irq_cnt = 0;
  int         n0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (irq_n_o === 1'b0) irq_cnt <= irq_cnt + 1;
  sssp_top #(.ADR_W(10)) sssp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sclk_i(sclk), .sdin_i(sd & oe_n), .sdout_o(sdout_o), .sdout_oe_n_o(oe_n),
    .irq_n_o(irq_n_o), .irq_o(irq_o));
  sssp_partner sssp_partner_inst (.sclk_o(sclk), .sd_o(sd), .oe_n_i(oe_n), .rx_o(rx));
  // ==========================================
  // Helpers
  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] dv, output logic [7:0] rq);
    int   n;
    logic got;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= sel_v;
    adr_i <= a;
    dat_i <= {24'h0, dv};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    got = (ack_o === 1'b1);
    rq = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (!got) begin
      error_cnt++;
      $display("[FAIL] ack exp 1 got 0");
      results();
    end
  endtask
  // Offset keeps the link edges away from the sampling clock edge
  task automatic serial(input sssp_byte_t tx, input int nb, input int half);
    #7;
    sssp_partner_inst.xfer(tx, nb, half);
    repeat (8) @(posedge clk_i);
  endtask
  // Both ends pull the shared line, so a zero from either wins
  function automatic sssp_byte_t line_and(sssp_byte_t a, sssp_byte_t b);
    return a & b;
  endfunction
  // ==========================================
  // Tests
  initial begin
    void'($urandom(32'h5F48));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
    chk("shift rst", 8'h00, q);
    wb(1'b1, `SSSP_ADR_CONFIG, 8'h01, q);
    wb(1'b0, `SSSP_ADR_CONFIG, 8'h00, q);
    chk("config", 8'h01, q);
    for (int i = 0; i < 4; i++) begin
      d = (i == 1) ? 8'hFF : 8'($urandom);
      p = (i == 0) ? 8'hFF : 8'($urandom);
      wb(1'b1, `SSSP_ADR_IRQ_ENABLE, 8'h00, q);
      wb(1'b1, `SSSP_ADR_SHIFT_DATA, d, q);
      wb(1'b0, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
      chk("readback", d, q);
      n0 = irq_cnt;
      serial(p, 8, (i == 2) ? 700 : 100);
      wb(1'b0, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
      chk("shift rx", line_and(d, p), q);
      chk("line rx", line_and(d, p), rx);
      chk("sdout", 8'h00, {7'h0, sdout_o});
      wb(1'b0, `SSSP_ADR_IRQ_STATUS, 8'h00, q);
      chk("status", 8'h01, q);
      chk("irq masked", 8'h00, {7'h0, irq_o});
      wb(1'b1, `SSSP_ADR_IRQ_ENABLE, 8'h01, q);
      wb(1'b0, `SSSP_ADR_IRQ_ENABLE, 8'h00, q);
      chk("enable", 8'h01, q);
      chk("irq level", 8'h01, {7'h0, irq_o});
      wb(1'b1, `SSSP_ADR_IRQ_CLEAR, 8'h01, q);
      chk("irq clr", 8'h00, {7'h0, irq_o});
      serial(8'h00, 3, 100);
      wb(1'b0, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
      chk("held", line_and(d, p), q);
      chk("pulses", 8'h01, 8'(irq_cnt - n0));
    end
    $display("test bytes done");
    n0 = irq_cnt;
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'hA5, q);
    serial(8'hFF, 4, 100);
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'h3C, q);
    serial(8'hFF, 7, 100);
    chk("early irq", 8'h00, 8'(irq_cnt - n0));
    serial(8'hFF, 1, 100);
    chk("eighth irq", 8'h01, 8'(irq_cnt - n0));
    $display("test restart done");
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'h5A, q);
    wb(1'b1, `SSSP_ADR_IRQ_DISABLE, 8'($urandom), q);
    wb(1'b0, `SSSP_ADR_IRQ_DISABLE, 8'h00, q);
    chk("dis read", 8'h00, q);
    n0 = irq_cnt;
    serial(8'hFF, 8, 100);
    chk("dis irq", 8'h00, 8'(irq_cnt - n0));
    $display("test disable done");
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'hC3, q);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    n0 = irq_cnt;
    serial(8'hFF, 8, 100);
    chk("rst irq", 8'h00, 8'(irq_cnt - n0));
    wb(1'b0, 10'h3F0, 8'h00, q);
    chk("unmapped", 8'h00, q);
    sel_v = 4'h0;
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
    sel_v = 4'hF;
    wb(1'b0, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
    chk("sel off", 8'hFF, q);
    wb(1'b1, `SSSP_ADR_SHIFT_DATA, 8'h00, q);
    chk("od off", 8'h01, {7'h0, oe_n});
    $display("test reset done");
    results();
  end
endmodule // testbench
`default_nettype wire
